//--- pae_defs.svh
`ifndef PAE_DEFS_SVH
`define PAE_DEFS_SVH
// Register byte offsets
`define PAE_OFF_CTRL      8'h00
`define PAE_OFF_SP        8'h04
`define PAE_OFF_SP_LIM    8'h08
`define PAE_OFF_SHIFT     8'h0C
`define PAE_OFF_CH1_DEV   8'h10
`define PAE_OFF_CH1_HYS   8'h14
`define PAE_OFF_CH1_SET   8'h18
`define PAE_OFF_CH1_CFG   8'h1C
`define PAE_OFF_CH2_DEV   8'h20
`define PAE_OFF_CH2_HYS   8'h24
`define PAE_OFF_CH2_SET   8'h28
`define PAE_OFF_CH2_CFG   8'h2C
`define PAE_OFF_STATUS    8'h30
`define PAE_OFF_PV        8'h34
// Control register fields
`define PAE_CTRL_LATCH_CLR 0
`define PAE_CTRL_SEC_IS_CT 1
`define PAE_CTRL_OUT_LINEAR 2
`define PAE_CTRL_SECOND_OUTPUT_ROLE_ALARM 3
// Channel config fields: function [3:0], mode [5:4]
`define PAE_CFG_MODE_LSB 4
// Reset values (tenths of a unit)
`define PAE_RST_SP_HIGH 16'h03E8
`define PAE_RST_HYS     16'h0001
// Heater current full scale, 50.0 A in 0.1 A steps
`define PAE_CT_FULL_SCALE 16'h01F4
// Loop-break window ceiling and tick rate
`define PAE_LB_MAX_S 120
`define PAE_CLK_HZ 50000000
`define PAE_TICKS_PER_S (`PAE_CLK_HZ)
`endif

//--- pae_pkg.sv
package pae_pkg;
  // Channel alarm functions
  typedef enum logic [3:0] {
    PAE_FN_NONE = 4'h0,
    PAE_FN_DEV_HIGH = 4'h1,
    PAE_FN_DEV_LOW = 4'h2,
    PAE_FN_BAND_HIGH = 4'h3,
    PAE_FN_BAND_LOW = 4'h4,
    PAE_FN_SEC_LOW = 4'h5,
    PAE_FN_LOOP_BREAK = 4'h6,
    PAE_FN_SENSOR_BREAK = 4'h7
  } pae_func_t;
  // Alarm modes
  typedef enum logic [1:0] {
    PAE_MD_NORMAL = 2'h0,
    PAE_MD_LATCH = 2'h1,
    PAE_MD_HOLD = 2'h2,
    PAE_MD_LATCH_HOLD = 2'h3
  } pae_mode_t;
  // Loop-break watch state, one-hot
  typedef enum logic [2:0] {
    PAE_LB_IDLE = 3'b001,
    PAE_LB_WATCH = 3'b010,
    PAE_LB_BROKEN = 3'b100
  } pae_lb_state_t;
endpackage

//--- pae_alarm_channel.sv
`timescale 1ns/1ps
`include "pae_defs.svh"
// One alarm channel: trigger levels, hysteresis and mode handling
module pae_alarm_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Process inputs
  input wire logic signed [W-1:0] primary_process_value_i,
  input wire logic signed [W-1:0] secondary_process_value_i,
  input wire logic signed [W-1:0] primary_setpoint_i,
  // Channel settings
  input wire logic signed [W-1:0] deviation_i,
  input wire logic signed [W-1:0] hysteresis_i,
  input wire logic signed [W-1:0] set_value_i,
  input wire pae_pkg::pae_func_t function_i,
  input wire pae_pkg::pae_mode_t mode_i,
  // Conditions from the controller
  input wire logic heater_break_allowed_i,
  input wire logic loop_break_allowed_i,
  input wire logic loop_broken_i,
  input wire logic failure_i,
  input wire logic latch_clear_i,
  // Result
  output logic alarm_o
);
  import pae_pkg::*;

  // Half hysteresis; sign kept so negative entries still work
  wire logic signed [W:0] half_hys = (W+1)'(hysteresis_i) >>> 1;
  // Centre of a deviation pair
  wire logic signed [W:0] dev_centre = (W+1)'(primary_setpoint_i) + (W+1)'(deviation_i);
  wire logic signed [W+1:0] dev_upper = (W+2)'(dev_centre) + (W+2)'(half_hys);  // RQ2
  wire logic signed [W+1:0] dev_lower = (W+2)'(dev_centre) - (W+2)'(half_hys);  // RQ2
  // Band edges, no hysteresis term
  wire logic signed [W+1:0] band_upper = (W+2)'(primary_setpoint_i) + (W+2)'(deviation_i);  // RQ5
  wire logic signed [W+1:0] band_lower = (W+2)'(primary_setpoint_i) - (W+2)'(deviation_i);  // RQ5
  // Heater-break levels around the set value
  wire logic signed [W+1:0] sec_upper = (W+2)'(set_value_i) + (W+2)'(half_hys);  // RQ8
  wire logic signed [W+1:0] sec_lower = (W+2)'(set_value_i) - (W+2)'(half_hys);  // RQ8
  wire logic signed [W+1:0] pv = (W+2)'(primary_process_value_i);
  wire logic signed [W+1:0] pv2 = (W+2)'(secondary_process_value_i);
  wire logic signed [W+1:0] sp = (W+2)'(primary_setpoint_i);
  wire logic band_lo_edge = (band_lower < band_upper) ? 1'b1 : 1'b0;
  // Band interval regardless of the deviation sign
  wire logic signed [W+1:0] band_min = band_lo_edge ? band_lower : band_upper;
  wire logic signed [W+1:0] band_max = band_lo_edge ? band_upper : band_lower;
  wire logic outside_band = (pv > band_max) || (pv < band_min);

  logic cond_reg;
  logic cond_next;
  logic armed_reg;
  logic latched_reg;

  // Condition with hysteresis memory for the level-type functions
  always_comb begin
    cond_next = 1'b0;
    unique case (function_i)
      PAE_FN_DEV_HIGH: begin
        // Set above upper level, release below lower
        cond_next = (pv > dev_upper) ? 1'b1 : ((pv < dev_lower) ? 1'b0 : cond_reg);  // RQ26
      end
      PAE_FN_DEV_LOW: begin
        cond_next = (pv < dev_lower) ? 1'b1 : ((pv > dev_upper) ? 1'b0 : cond_reg);  // RQ26
      end
      PAE_FN_BAND_HIGH: cond_next = outside_band;  // RQ27 RQ6
      PAE_FN_BAND_LOW: cond_next = !outside_band;  // RQ27 RQ6
      PAE_FN_SEC_LOW: begin
        // Heater break is disabled on linear heating outputs
        if (!heater_break_allowed_i) begin  // RQ9
          cond_next = 1'b0;
        end else begin
          cond_next = (pv2 < sec_lower) ? 1'b1 : ((pv2 > sec_upper) ? 1'b0 : cond_reg);  // RQ8
        end
      end
      PAE_FN_LOOP_BREAK: cond_next = loop_break_allowed_i & loop_broken_i;  // RQ11 RQ14
      PAE_FN_SENSOR_BREAK: cond_next = failure_i;  // RQ15 RQ16
      default: cond_next = 1'b0;
    endcase
  end

  // Holding does not apply to the break functions
  wire logic break_fn = (function_i == PAE_FN_LOOP_BREAK) || (function_i == PAE_FN_SENSOR_BREAK);  // RQ12 RQ17
  wire logic hold_sel = ((mode_i == PAE_MD_HOLD) || (mode_i == PAE_MD_LATCH_HOLD)) && !break_fn;  // RQ4
  wire logic latch_sel = (mode_i == PAE_MD_LATCH) || (mode_i == PAE_MD_LATCH_HOLD);  // RQ4
  // Sensor break reacts at once, not one cycle late
  wire logic active = (function_i == PAE_FN_SENSOR_BREAK) ? failure_i : cond_next;  // RQ15
  wire logic gated = active & (armed_reg | !hold_sel);  // RQ25
  wire logic reached = (pv >= sp);

  // Hysteresis memory
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cond_reg <= 1'b0;
    end else begin
      cond_reg <= cond_next;
    end
  end

  // Holding arm: first reaching of setpoint after power-up
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_reg <= 1'b0;
    end else if (reached) begin
      armed_reg <= 1'b1;  // RQ25
    end
  end

  // Latch store; a new alarm wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latched_reg <= 1'b0;  // RQ24
    end else if (latch_sel && gated) begin
      latched_reg <= 1'b1;  // RQ23
    end else if (latch_clear_i || !latch_sel) begin
      latched_reg <= 1'b0;  // RQ24
    end
  end

  // Output energize, registered
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_o <= 1'b0;
    end else begin
      alarm_o <= gated | (latch_sel & latched_reg);  // RQ22 RQ23
    end
  end

  // Latched output stays set until a clear
  latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ23
    (alarm_o && latch_sel && !latch_clear_i && !$past(latch_clear_i) && $stable(mode_i)) |=> alarm_o)
    else $error("latched alarm dropped");
  // Normal mode follows the condition one cycle later
  normal_follow_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ22
    (mode_i == PAE_MD_NORMAL && $stable(mode_i)) |=> (alarm_o == $past(active)))
    else $error("normal alarm mismatch");
  // Holding suppresses before setpoint is reached
  hold_block_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ25
    (hold_sel && !armed_reg && !latched_reg) |=> !alarm_o)
    else $error("holding alarm fired early");
  // Sensor break follows failure
  sensor_break_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ15
    (function_i == PAE_FN_SENSOR_BREAK && failure_i) |=> alarm_o)
    else $error("sensor break missed");
  // Heater break blocked on linear output
  heater_lin_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ9
    (function_i == PAE_FN_SEC_LOW && !heater_break_allowed_i && !latch_sel) |=> !alarm_o)
    else $error("heater break on linear output");
endmodule // pae_alarm_channel

//--- pae_alarm_evaluator.sv
// Notes on behaviour
// (RQ1) Each channel has signed deviation, hysteresis
// (RQ2) Deviation levels: setpoint plus deviation, half-hysteresis
// (RQ3) High-side and low-side deviation functions
// (RQ4) Four modes: normal, latch, hold, both
// (RQ5) Band levels: setpoint plus/minus deviation
// (RQ6) Band-high and band-low variants per channel
// (RQ7) Secondary value is heater current, 0.1 A
// (RQ8) Heater break: low alarm on secondary value
// (RQ9) No heater break with linear output
// (RQ10) Keep output cycle at least one second
// (RQ11) Loop break; channel 2 needs output role
// (RQ12) Loop break ignores holding modes
// (RQ13) Loop window twice integral time, 120 s max
// (RQ14) Control saturated, process not moving: break
// (RQ15) Sensor break asserts on failure at once
// (RQ16) Converter failure also means sensor break
// (RQ17) Sensor break ignores holding modes
// (RQ18) Setpoint clamped between low and high limits
// (RQ19) Shift added to primary value only
// (RQ20) Hysteresis normally set to minimum 0.1
// (RQ21) Channel 2 behaves like channel 1
// (RQ22) Normal: energized only while condition holds
// (RQ23) Latching: stays energized after condition clears
// (RQ24) Latch released by reset or event clear
// (RQ25) Holding suppressed until setpoint first reached
// (RQ26) Deviation high sets above, releases below
// (RQ27) Band-high outside band, band-low inside
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pae_defs.svh"
module pae_alarm_evaluator #(
  parameter int W = 16,
  parameter int TICKS_PER_S = `PAE_TICKS_PER_S
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Measurement front ends
  input wire logic signed [W-1:0] raw_primary_value_i,
  input wire logic [W-1:0] heater_current_raw_i,
  input wire logic signed [W-1:0] raw_secondary_value_i,
  input wire logic [W-1:0] primary_control_variable_i,
  input wire logic [W-1:0] control_max_i,
  input wire logic [W-1:0] control_min_i,
  input wire logic [7:0] primary_integral_time_i,
  // Failure sources and event input
  input wire logic sensor_fail_i,
  input wire logic adc_fail_i,
  input wire logic event_latch_clear_i,
  // Alarm relays and process values
  output logic alarm1_o,
  output logic alarm2_o,
  output logic signed [W-1:0] primary_process_value_o,
  output logic signed [W-1:0] secondary_process_value_o
);
  import pae_pkg::*;

  // Software settings
  logic [3:0] ctrl_reg;
  logic signed [W-1:0] sp_reg;
  logic signed [W-1:0] sp_low_reg;
  logic signed [W-1:0] sp_high_reg;
  logic signed [W-1:0] shift_reg;
  logic signed [W-1:0] dev_reg [2];  // RQ1
  logic signed [W-1:0] hys_reg [2];  // RQ1
  logic signed [W-1:0] set_reg [2];
  logic [5:0] cfg_reg [2];
  logic lclr_pulse_reg;
  logic [31:0] rdata_next;
  logic addr_ok;
  pae_lb_state_t lb_state_reg;

  // Write strobe in the access phase; slave always ready
  wire logic wr_en = psel_i & penable_i & pwrite_i;
  wire logic rd_en = psel_i & penable_i & !pwrite_i;
  wire logic signed [W-1:0] wdata = pwdata_i[W-1:0];

  // Setpoint clamp into the configured range
  wire logic signed [W-1:0] sp_clamped = (wdata < sp_low_reg) ? sp_low_reg :  // RQ18
                                         ((wdata > sp_high_reg) ? sp_high_reg : wdata);  // RQ18

  // Shift applies to the primary value only
  wire logic signed [W:0] pv1_sum = (W+1)'(raw_primary_value_i) + (W+1)'(shift_reg);  // RQ19
  // Secondary: heater current clamped to 50.0 A when a CT is fitted
  wire logic [W-1:0] ct_val = (heater_current_raw_i > W'(`PAE_CT_FULL_SCALE)) ?
                              W'(`PAE_CT_FULL_SCALE) : heater_current_raw_i;  // RQ7
  wire logic signed [W-1:0] pv2_next = ctrl_reg[`PAE_CTRL_SEC_IS_CT] ? $signed(ct_val)
                                       : raw_secondary_value_i;  // RQ7 RQ19

  // Failure mode: sensor fault or converter fault
  wire logic failure = sensor_fail_i | adc_fail_i;  // RQ16

  // Register write port
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= 4'h0;
      sp_reg <= '0;
      sp_low_reg <= '0;
      sp_high_reg <= W'(`PAE_RST_SP_HIGH);
      shift_reg <= '0;
      lclr_pulse_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        dev_reg[i] <= '0;
        hys_reg[i] <= W'(`PAE_RST_HYS);
        set_reg[i] <= '0;
        cfg_reg[i] <= 6'h00;
      end
    end else begin
      // Latch clear is a self-clearing strobe
      lclr_pulse_reg <= wr_en && (paddr_i == `PAE_OFF_CTRL) && pwdata_i[`PAE_CTRL_LATCH_CLR];
      if (wr_en) begin
        unique case (paddr_i)
          `PAE_OFF_CTRL: ctrl_reg <= {pwdata_i[3:1], 1'b0};
          `PAE_OFF_SP: sp_reg <= sp_clamped;  // RQ18
          `PAE_OFF_SP_LIM: begin
            sp_low_reg <= pwdata_i[W-1:0];
            sp_high_reg <= pwdata_i[2*W-1:W];
          end
          `PAE_OFF_SHIFT: shift_reg <= wdata;
          `PAE_OFF_CH1_DEV: dev_reg[0] <= wdata;
          `PAE_OFF_CH1_HYS: hys_reg[0] <= wdata;
          `PAE_OFF_CH1_SET: set_reg[0] <= wdata;
          `PAE_OFF_CH1_CFG: cfg_reg[0] <= pwdata_i[5:0];
          `PAE_OFF_CH2_DEV: dev_reg[1] <= wdata;
          `PAE_OFF_CH2_HYS: hys_reg[1] <= wdata;
          `PAE_OFF_CH2_SET: set_reg[1] <= wdata;
          `PAE_OFF_CH2_CFG: cfg_reg[1] <= pwdata_i[5:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr_i)
      `PAE_OFF_CTRL: rdata_next = {28'h000_0000, ctrl_reg};
      `PAE_OFF_SP: rdata_next = 32'(sp_reg);
      `PAE_OFF_SP_LIM: rdata_next = {sp_high_reg, sp_low_reg};
      `PAE_OFF_SHIFT: rdata_next = 32'(shift_reg);
      `PAE_OFF_CH1_DEV: rdata_next = 32'(dev_reg[0]);
      `PAE_OFF_CH1_HYS: rdata_next = 32'(hys_reg[0]);
      `PAE_OFF_CH1_SET: rdata_next = 32'(set_reg[0]);
      `PAE_OFF_CH1_CFG: rdata_next = {26'h000_0000, cfg_reg[0]};
      `PAE_OFF_CH2_DEV: rdata_next = 32'(dev_reg[1]);
      `PAE_OFF_CH2_HYS: rdata_next = 32'(hys_reg[1]);
      `PAE_OFF_CH2_SET: rdata_next = 32'(set_reg[1]);
      `PAE_OFF_CH2_CFG: rdata_next = {26'h000_0000, cfg_reg[1]};
      `PAE_OFF_STATUS: rdata_next = {27'h000_0000, lb_state_reg == PAE_LB_BROKEN, failure,
                                     alarm2_o, alarm1_o, 1'b0};
      `PAE_OFF_PV: rdata_next = {secondary_process_value_o, primary_process_value_o};
      default: addr_ok = 1'b0;
    endcase
  end

  // Registered APB answer: zero wait states
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & !penable_i;
      pslverr_o <= psel_i & !penable_i & !addr_ok;
      if (psel_i & !penable_i) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // Process values out
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      primary_process_value_o <= '0;
      secondary_process_value_o <= '0;
    end else begin
      primary_process_value_o <= pv1_sum[W-1:0];  // RQ19
      secondary_process_value_o <= pv2_next;
    end
  end

  // Loop-break watch: window 2*TI seconds, capped
  pae_lb_state_t lb_state_next;
  logic [31:0] lb_tick_reg;
  logic [7:0] lb_sec_reg;
  logic signed [W-1:0] lb_pv_reg;
  logic lb_dir_reg;
  wire logic [8:0] lb_twice = {primary_integral_time_i, 1'b0};
  wire logic [7:0] lb_window = (lb_twice > 9'(`PAE_LB_MAX_S)) ? 8'(`PAE_LB_MAX_S) : lb_twice[7:0];  // RQ13
  wire logic cv_max = primary_control_variable_i >= control_max_i;
  wire logic cv_min = primary_control_variable_i <= control_min_i;
  wire logic sat = cv_max | cv_min;
  wire logic sec_tick = (lb_tick_reg == 32'(TICKS_PER_S - 1));
  // Process responded in the wanted direction
  wire logic moved = lb_dir_reg ? (primary_process_value_o > lb_pv_reg) : (primary_process_value_o < lb_pv_reg);  // RQ14
  wire logic lb_sat_same = lb_dir_reg ? cv_max : cv_min;

  // Watch state transitions
  always_comb begin
    lb_state_next = lb_state_reg;
    unique case (lb_state_reg)
      PAE_LB_IDLE: if (sat && lb_window != 8'h00) lb_state_next = PAE_LB_WATCH;
      PAE_LB_WATCH: begin
        if (!lb_sat_same || moved) begin
          lb_state_next = PAE_LB_IDLE;
        end else if (sec_tick && lb_sec_reg + 8'h01 >= lb_window) begin
          lb_state_next = PAE_LB_BROKEN;  // RQ13 RQ14
        end
      end
      PAE_LB_BROKEN: if (!lb_sat_same || moved) lb_state_next = PAE_LB_IDLE;
      default: lb_state_next = PAE_LB_IDLE;
    endcase
  end

  // Watch timers and reference value
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lb_state_reg <= PAE_LB_IDLE;
      lb_tick_reg <= 32'h0000_0000;
      lb_sec_reg <= 8'h00;
      lb_pv_reg <= '0;
      lb_dir_reg <= 1'b0;
    end else begin
      lb_state_reg <= lb_state_next;
      if (lb_state_reg == PAE_LB_IDLE) begin
        lb_tick_reg <= 32'h0000_0000;
        lb_sec_reg <= 8'h00;
        lb_pv_reg <= primary_process_value_o;
        lb_dir_reg <= cv_max;
      end else begin
        lb_tick_reg <= sec_tick ? 32'h0000_0000 : lb_tick_reg + 32'h0000_0001;
        if (sec_tick && lb_sec_reg != 8'hFF) lb_sec_reg <= lb_sec_reg + 8'h01;
      end
    end
  end

  wire logic loop_broken = (lb_state_reg == PAE_LB_BROKEN);
  logic [1:0] alarm_w;

  // Two channels, alike except that channel 2 allows loop break only with the output role bit set
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      pae_alarm_channel #(.W(W)) u_ch (  // RQ21
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .primary_process_value_i(primary_process_value_o),
        .secondary_process_value_i(secondary_process_value_o),
        .primary_setpoint_i(sp_reg),
        .deviation_i(dev_reg[c]),
        .hysteresis_i(hys_reg[c]),
        .set_value_i(set_reg[c]),
        .function_i(pae_func_t'(cfg_reg[c][3:0])),  // RQ3
        .mode_i(pae_mode_t'(cfg_reg[c][`PAE_CFG_MODE_LSB+1:`PAE_CFG_MODE_LSB])),
        .heater_break_allowed_i(!ctrl_reg[`PAE_CTRL_OUT_LINEAR]),  // RQ9
        .loop_break_allowed_i((c == 0) ? 1'b1 : ctrl_reg[`PAE_CTRL_SECOND_OUTPUT_ROLE_ALARM]),  // RQ11
        .loop_broken_i(loop_broken),
        .failure_i(failure),
        .latch_clear_i(lclr_pulse_reg | event_latch_clear_i),  // RQ24
        .alarm_o(alarm_w[c])
      );
    end
  endgenerate

  // Relay drive straight from flip-flops
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm1_o <= 1'b0;
      alarm2_o <= 1'b0;
    end else begin
      alarm1_o <= alarm_w[0];
      alarm2_o <= alarm_w[1];
    end
  end

  // Stored setpoint stays inside limits after a write
  sp_clamp_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ18
    (wr_en && paddr_i == `PAE_OFF_SP && $stable(sp_low_reg) && $stable(sp_high_reg) && sp_low_reg <= sp_high_reg)
    |=> (sp_reg >= sp_low_reg && sp_reg <= sp_high_reg))
    else $error("setpoint outside limits");
  // Primary value carries the shift
  pv_shift_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ19
    1'b1 |=> (primary_process_value_o == $past(pv1_sum[W-1:0])))
    else $error("shift not applied");
  // Broken state only after saturation
  lb_sat_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)  // RQ14
    $rose(loop_broken) |-> $past(lb_sat_same))
    else $error("loop break without saturation");
endmodule // pae_alarm_evaluator

//--- pae_plant_model.sv
`timescale 1ns/1ps
// Far-side model: sensor, CT and controller front ends, sampled once per clock
module pae_plant_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Plant state wanted by the bench
  input wire logic signed [15:0] temp_i,
  input wire logic [15:0] amps_i,
  input wire logic [15:0] drive_i,
  input wire logic broken_i,
  input wire logic conv_bad_i,
  // Front-end outputs
  output logic signed [15:0] raw_pv_o,
  output logic signed [15:0] raw_sec_o,
  output logic [15:0] ct_o,
  output logic [15:0] mv_o,
  output logic sensor_fail_o,
  output logic adc_fail_o
);
  // One register stage, like a converter; no filtering, so steps reach the block unchanged
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      raw_pv_o <= 16'h0000;
      raw_sec_o <= 16'h0000;
      ct_o <= 16'h0000;
      mv_o <= 16'h0000;
      sensor_fail_o <= 1'b0;
      adc_fail_o <= 1'b0;
    end else begin
      raw_pv_o <= temp_i;
      raw_sec_o <= 16'h0007; // Fixed auxiliary reading, never shifted
      ct_o <= amps_i; // Current held for many cycles, as a slow output cycle gives
      mv_o <= drive_i;
      sensor_fail_o <= broken_i;
      adc_fail_o <= conv_bad_i;
    end
  end
endmodule // pae_plant_model

//--- testbench.sv
`timescale 1ns/1ps
`include "pae_defs.svh"
module testbench;
  import pae_pkg::*;
  // Clock, reset and bus master signals
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, alarm1, alarm2, sfail, afail;
  // Plant wishes and front-end outputs
  logic signed [15:0] temp = 16'h0000, raw_pv, raw_sec, pv_o, sec_o;
  logic [15:0] amps = 16'h0000, drive = 16'h0200, ct, mv;
  logic broken = 1'b0, conv_bad = 1'b0, evt_clr = 1'b0;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  // Short ticks make the loop-break window 20 cycles for an integral time of 1 s
  pae_alarm_evaluator #(.W(16), .TICKS_PER_S(10)) i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .raw_primary_value_i(raw_pv), .heater_current_raw_i(ct), .raw_secondary_value_i(raw_sec),
    .primary_control_variable_i(mv), .control_max_i(16'h03E8), .control_min_i(16'h0010),
    .primary_integral_time_i(8'h01), .sensor_fail_i(sfail), .adc_fail_i(afail), .event_latch_clear_i(evt_clr),
    .alarm1_o(alarm1), .alarm2_o(alarm2), .primary_process_value_o(pv_o), .secondary_process_value_o(sec_o));
  // Far side
  pae_plant_model i_plant (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .temp_i(temp), .amps_i(amps),
    .drive_i(drive), .broken_i(broken), .conv_bad_i(conv_bad), .raw_pv_o(raw_pv), .raw_sec_o(raw_sec),
    .ct_o(ct), .mv_o(mv), .sensor_fail_o(sfail), .adc_fail_o(afail));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_w(rd, exp);
  endtask
  // New process value, then both alarms after the pipeline has settled
  task automatic step(input logic signed [15:0] v, input logic e1, input logic e2);
    temp <= v;
    cyc(8);
    chk_b(alarm1, e1);
    chk_b(alarm2, e2);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("mismatch at %0t: run did not finish", $time);
      results();
    end
  end
  initial begin
    cyc(2);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc(`PAE_OFF_SP_LIM, {`PAE_RST_SP_HIGH, 16'h0000});
    rdc(`PAE_OFF_CH2_HYS, 32'h0000_0001);
    rdc(8'h3C, 32'h0000_0000);
    chk_b(err, 1'b1);
    done("reset values");
    wr(`PAE_OFF_SP_LIM, 32'h00C8_0032);
    wr(`PAE_OFF_SP, 32'h0000_01F4);
    rdc(`PAE_OFF_SP, 32'h0000_00C8);
    wr(`PAE_OFF_SP, 32'h0000_0010);
    rdc(`PAE_OFF_SP, 32'h0000_0032);
    wr(`PAE_OFF_SP_LIM, 32'h03E8_0000);
    wr(`PAE_OFF_SP, 32'h0000_0064);
    done("setpoint clamp");
    wr(`PAE_OFF_SHIFT, 32'h0000_FFDD);
    step(16'sd100, 1'b0, 1'b0);
    rdc(`PAE_OFF_PV, 32'h0007_0041);
    chk_w({16'h0000, pv_o}, 32'h0000_0041);
    wr(`PAE_OFF_SHIFT, 32'h0000_0000);
    done("shift");
    // Levels 112 and 108 around 110
    wr(`PAE_OFF_CH1_DEV, 32'h0000_000A);
    wr(`PAE_OFF_CH1_HYS, 32'h0000_0004);
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0001);
    step(16'sd113, 1'b1, 1'b0);
    step(16'sd110, 1'b1, 1'b0);
    step(16'sd107, 1'b0, 1'b0);
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0011);
    step(16'sd113, 1'b1, 1'b0);
    step(16'sd90, 1'b1, 1'b0);
    evt_clr <= 1'b1;
    cyc(4);
    evt_clr <= 1'b0;
    step(16'sd90, 1'b0, 1'b0);
    step(16'sd113, 1'b1, 1'b0);
    temp <= 16'sd90;
    wr(`PAE_OFF_CTRL, 32'h0000_0001);
    step(16'sd90, 1'b0, 1'b0);
    done("deviation high and latch");
    // Channel 2 low side: levels 92 and 88
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0000);
    wr(`PAE_OFF_CH2_DEV, 32'h0000_FFF6);
    wr(`PAE_OFF_CH2_HYS, 32'h0000_0004);
    wr(`PAE_OFF_CH2_CFG, 32'h0000_0002);
    step(16'sd87, 1'b0, 1'b1);
    step(16'sd90, 1'b0, 1'b1);
    step(16'sd93, 1'b0, 1'b0);
    done("deviation low");
    // Band 95..105, no hysteresis term
    wr(`PAE_OFF_CH1_DEV, 32'h0000_0005);
    wr(`PAE_OFF_CH2_DEV, 32'h0000_0005);
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0003);
    wr(`PAE_OFF_CH2_CFG, 32'h0000_0004);
    step(16'sd100, 1'b0, 1'b1);
    step(16'sd106, 1'b1, 1'b0);
    step(16'sd94, 1'b1, 1'b0);
    done("band");
    // Holding selections must not delay a sensor break
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0037);
    wr(`PAE_OFF_CH2_CFG, 32'h0000_0027);
    for (int i = 0; i < 2; i++) begin
      broken <= (i == 0);
      conv_bad <= (i == 1);
      cyc(4);
      chk_b(alarm1, 1'b1);
      chk_b(alarm2, 1'b1);
      broken <= 1'b0;
      conv_bad <= 1'b0;
      step(16'sd100, 1'b1, 1'b0);
    end
    done("sensor break");
    // Heater current 12.0 A against a 13.0 A set value
    wr(`PAE_OFF_CTRL, 32'h0000_0002);
    wr(`PAE_OFF_CH2_CFG, 32'h0000_0000);
    wr(`PAE_OFF_CH1_SET, 32'h0000_0082);
    wr(`PAE_OFF_CH1_HYS, 32'h0000_0001);
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0005);
    amps <= 16'h0078;
    step(16'sd100, 1'b1, 1'b0);
    rdc(`PAE_OFF_PV, 32'h0078_0064);
    amps <= 16'h008C;
    step(16'sd100, 1'b0, 1'b0);
    amps <= 16'h0078;
    wr(`PAE_OFF_CTRL, 32'h0000_0006);
    step(16'sd100, 1'b0, 1'b0);
    done("heater break");
    // Saturated drive, steady value; channel 2 lacks the output role
    wr(`PAE_OFF_CTRL, 32'h0000_0000);
    wr(`PAE_OFF_CH1_CFG, 32'h0000_0026);
    wr(`PAE_OFF_CH2_CFG, 32'h0000_0006);
    drive <= 16'h03E8;
    cyc(10);
    chk_b(alarm1, 1'b0);
    cyc(30);
    chk_b(alarm1, 1'b1);
    chk_b(alarm2, 1'b0);
    drive <= 16'h0200;
    cyc(8);
    chk_b(alarm1, 1'b0);
    done("loop break");
    results();
  end
endmodule // testbench
